// [logic/ec_mailbox_power_sequencer.sv]
// Operation
// - host reaches all 44 mailbox registers through two i/o ports.
// - a host write to mailbox 0 pulses the controller interrupt.
// - a controller write to mailbox 1 pulses the host smi when enabled.
// - other mailbox registers are shared; firmware avoids collisions.
// - after power up the boot code checksums the external flash.
// - a bad checksum enters recovery: blink leds, poll parallel port.
// - a good checksum runs from flash, then waits for the power switch.
// - a switch press drives resume reset active to request power.
// - after power good system reset is held and a timer started.
// - on timer expiry reset releases, clock stops, rom goes to host.
// - host restarts the controller clock and loses the rom in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module ec_mailbox_power_sequencer #(
    parameter int BLINK_CYCLES = ec_seq_pkg::BLINK_CYCLES,
    parameter int HOLD_CYCLES  = ec_seq_pkg::HOLD_CYCLES,
    parameter int FLASH_BYTES  = ec_seq_pkg::FLASH_BYTES
) (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       host_wr_i,
    input  wire logic       host_rd_i,
    input  wire logic       host_port_i,
    input  wire logic [7:0] host_wdata_i,
    output logic      [7:0] host_rdata_o,
    input  wire logic       ec_wr_i,
    input  wire logic [5:0] ec_addr_i,
    input  wire logic [7:0] ec_wdata_i,
    output logic      [7:0] ec_rdata_o,
    input  wire logic       smi_enable_i,
    output logic            ec_irq_o,
    output logic            system_management_interrupt_o,
    input  wire logic       flash_valid_i,
    input  wire logic [7:0] flash_byte_i,
    output logic            flash_req_o,
    output logic            power_switch_pin_i_unused_o,
    input  wire logic       power_switch_i,
    input  wire logic       power_good_in_i,
    input  wire logic       parallel_host_i,
    input  wire logic       clock_restart_i,
    output logic            resume_reset_out_n_o,
    output logic            system_reset_out_n_o,
    output logic            rom_to_host_o,
    output logic            ec_clock_run_o,
    output logic            recovery_o,
    output logic            led_blink_o,
    output logic            program_port_ready_o
);
    typedef enum logic [7:0] {
        S_SUM     = 8'h01,
        S_RECOVER = 8'h02,
        S_WAIT_SW = 8'h04,
        S_WAIT_PG = 8'h08,
        S_HOLD    = 8'h10,
        S_HOST    = 8'h20,
        S_RUN     = 8'h40
    } state_type;

    // pin synchronisers
    logic [1:0] sw_sync, pg_sync, par_sync, clk_sync;
    always_ff @(posedge clock_i) begin
        sw_sync  <= {sw_sync[0], power_switch_i};
        pg_sync  <= {pg_sync[0], power_good_in_i};
        par_sync <= {par_sync[0], parallel_host_i};
        clk_sync <= {clk_sync[0], clock_restart_i};
    end

    // mailbox host side
    logic [5:0] index, next_index;
    logic [7:0] host_rdata, ram_a, ram_b;
    logic       host_data_wr, ec_irq, next_ec_irq, system_management_interrupt, next_smi;

    assign host_data_wr = host_wr_i && host_port_i == ec_seq_pkg::PORT_DATA;

    always_comb begin
        next_index  = index;
        next_ec_irq = 1'b0;
        next_smi    = 1'b0;
        if (host_wr_i && host_port_i == ec_seq_pkg::PORT_INDEX) begin
            next_index = host_wdata_i[5:0];
        end
        if (host_data_wr && index == ec_seq_pkg::MBOX_HOST_MSG) begin
            next_ec_irq = 1'b1;
        end
        if (ec_wr_i && ec_addr_i == ec_seq_pkg::MBOX_EC_MSG
            && smi_enable_i) begin
            next_smi = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            index  <= 6'h00;
            ec_irq <= 1'b0;
            system_management_interrupt    <= 1'b0;
        end else begin
            index  <= next_index;
            ec_irq <= next_ec_irq;
            system_management_interrupt    <= next_smi;
        end
    end

    // shared storage; host wins a same-cycle collision
    mailbox_ram u_ram (
        .clock_i   (clock_i),
        .we_a_i    (host_data_wr),
        .addr_a_i  (index),
        .wdata_a_i (host_wdata_i),
        .rdata_a_o (ram_a),
        .we_b_i    (ec_wr_i),
        .addr_b_i  (ec_addr_i),
        .wdata_b_i (ec_wdata_i),
        .rdata_b_o (ram_b)
    );

    logic read_idx;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            read_idx <= 1'b0;
        end else begin
            read_idx <= host_rd_i && host_port_i == ec_seq_pkg::PORT_INDEX;
        end
    end
    assign host_rdata = read_idx ? {2'h0, index} : ram_a;

    // power sequencer
    state_type  state, next_state;
    logic [7:0] sum, next_sum;
    logic [31:0] cnt, next_cnt;
    logic       blink, next_blink;

    always_comb begin
        next_state = state;
        next_sum   = sum;
        next_cnt   = cnt;
        next_blink = blink;
        unique case (state)
            S_SUM: begin
                if (flash_valid_i) begin
                    next_sum = sum + flash_byte_i;
                    next_cnt = cnt + 32'h1;
                    if (cnt == 32'(FLASH_BYTES - 1)) begin
                        next_cnt = 32'h0;
                        next_state = (next_sum == ec_seq_pkg::FLASH_SUM_GOOD)
                                   ? S_WAIT_SW : S_RECOVER;
                    end
                end
            end
            S_RECOVER: begin
                next_cnt = cnt + 32'h1;
                if (cnt >= 32'(BLINK_CYCLES - 1)) begin
                    next_cnt   = 32'h0;
                    next_blink = ~blink;
                end
            end
            S_WAIT_SW: if (sw_sync[1]) next_state = S_WAIT_PG;
            S_WAIT_PG: if (pg_sync[1]) begin
                next_state = S_HOLD;
                next_cnt   = 32'h0;
            end
            S_HOLD: begin
                next_cnt = cnt + 32'h1;
                if (cnt >= 32'(HOLD_CYCLES - 1)) next_state = S_HOST;
            end
            S_HOST: if (clk_sync[1]) next_state = S_RUN;
            S_RUN: next_state = S_RUN;
            default: next_state = S_SUM;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= S_SUM;
            sum   <= 8'h00;
            cnt   <= 32'h0;
            blink <= 1'b0;
        end else begin
            state <= next_state;
            sum   <= next_sum;
            cnt   <= next_cnt;
            blink <= next_blink;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            host_rdata_o                  <= 8'h00;
            ec_rdata_o                    <= 8'h00;
            ec_irq_o                      <= 1'b0;
            system_management_interrupt_o <= 1'b0;
            flash_req_o                   <= 1'b0;
            power_switch_pin_i_unused_o   <= 1'b0;
            resume_reset_out_n_o          <= 1'b1;
            system_reset_out_n_o          <= 1'b0;
            rom_to_host_o                 <= 1'b0;
            ec_clock_run_o                <= 1'b1;
            recovery_o                    <= 1'b0;
            led_blink_o                   <= 1'b0;
            program_port_ready_o          <= 1'b0;
        end else begin
            host_rdata_o                  <= host_rdata;
            ec_rdata_o                    <= ram_b;
            ec_irq_o                      <= ec_irq;
            system_management_interrupt_o <= system_management_interrupt;
            flash_req_o                   <= next_state == S_SUM;
            power_switch_pin_i_unused_o   <= 1'b0;
            resume_reset_out_n_o          <= !(next_state inside
                {S_WAIT_PG, S_HOLD, S_HOST, S_RUN});
            system_reset_out_n_o          <= next_state inside
                {S_HOST, S_RUN};
            rom_to_host_o                 <= next_state == S_HOST;
            ec_clock_run_o                <= next_state != S_HOST;
            recovery_o                    <= next_state == S_RECOVER;
            led_blink_o                   <= next_blink;
            program_port_ready_o          <= next_state == S_RECOVER
                                             && par_sync[1];
        end
    end

    chk_host_msg_irq: assert property (@(posedge clock_i) disable iff (rst_i)
        host_data_wr && index == ec_seq_pkg::MBOX_HOST_MSG |-> ##2 ec_irq_o)
        else $error("no controller irq after host msg write");
    chk_ec_msg_smi: assert property (@(posedge clock_i) disable iff (rst_i)
        ec_wr_i && ec_addr_i == ec_seq_pkg::MBOX_EC_MSG && smi_enable_i
        |-> ##2 system_management_interrupt_o)
        else $error("no smi after controller msg write");
    chk_smi_gated: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(smi_enable_i, 2) |-> !system_management_interrupt_o)
        else $error("smi while disabled");
    chk_index_write: assert property (@(posedge clock_i) disable iff (rst_i)
        host_wr_i && host_port_i == ec_seq_pkg::PORT_INDEX
        |=> index == $past(host_wdata_i[5:0]))
        else $error("index not captured");
    chk_reset_order: assert property (@(posedge clock_i) disable iff (rst_i)
        system_reset_out_n_o |-> !resume_reset_out_n_o)
        else $error("reset released before power request");
    chk_rom_clock: assert property (@(posedge clock_i) disable iff (rst_i)
        rom_to_host_o |-> !ec_clock_run_o && system_reset_out_n_o)
        else $error("rom handed over with clock running");
    chk_hold_reset: assert property (@(posedge clock_i) disable iff (rst_i)
        state == S_HOLD |-> !system_reset_out_n_o)
        else $error("reset released during hold");
    chk_clock_back: assert property (@(posedge clock_i) disable iff (rst_i)
        state == S_RUN |=> !rom_to_host_o && ec_clock_run_o)
        else $error("rom not reclaimed");
    chk_recover: assert property (@(posedge clock_i) disable iff (rst_i)
        state == S_RECOVER |=> recovery_o && resume_reset_out_n_o)
        else $error("recovery requested power");
    chk_boot_sum: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(flash_req_o) |-> $past(rst_i, 1) || state == S_SUM)
        else $error("flash read outside checksum");

    cov_recover: cover property (@(posedge clock_i) state == S_RECOVER);
    cov_host: cover property (@(posedge clock_i) rom_to_host_o);
    cov_run: cover property (@(posedge clock_i) state == S_RUN);
    cov_smi: cover property (@(posedge clock_i) system_management_interrupt_o);
endmodule
`default_nettype wire

// [logic/ec_seq_pkg.sv]
package ec_seq_pkg;
    localparam int          MBOX_COUNT      = 44;
    localparam int          MBOX_AW         = 6;
    localparam logic [5:0]  MBOX_HOST_MSG   = 6'h00;
    localparam logic [5:0]  MBOX_EC_MSG     = 6'h01;
    localparam logic [5:0]  MBOX_LAST       = 6'h2B;
    localparam logic [7:0]  MBOX_RESET_VAL  = 8'h00;
    localparam logic [0:0]  PORT_INDEX      = 1'h0;
    localparam logic [0:0]  PORT_DATA       = 1'h1;
    localparam logic [7:0]  FLASH_SUM_GOOD  = 8'h00;
    localparam int          FLASH_BYTES     = 524288;
    localparam int          CLK_MHZ         = 100;
    localparam int          BLINK_US        = 250000;
    localparam int          BLINK_CYCLES    = BLINK_US * CLK_MHZ;
    localparam int          HOLD_US         = 1000;
    localparam int          HOLD_CYCLES     = HOLD_US * CLK_MHZ;
endpackage

// [logic/mailbox_ram.sv]
`timescale 1ns/1ns
`default_nettype none
module mailbox_ram (
    input  wire logic       clock_i,
    input  wire logic       we_a_i,
    input  wire logic [5:0] addr_a_i,
    input  wire logic [7:0] wdata_a_i,
    output logic      [7:0] rdata_a_o,
    input  wire logic       we_b_i,
    input  wire logic [5:0] addr_b_i,
    input  wire logic [7:0] wdata_b_i,
    output logic      [7:0] rdata_b_o
);
    logic [7:0] mem [0:ec_seq_pkg::MBOX_COUNT-1];

    always_ff @(posedge clock_i) begin
        if (we_a_i && addr_a_i <= ec_seq_pkg::MBOX_LAST) begin
            mem[addr_a_i] <= wdata_a_i;
        end else if (we_b_i && addr_b_i <= ec_seq_pkg::MBOX_LAST) begin
            mem[addr_b_i] <= wdata_b_i;
        end
        rdata_a_o <= (addr_a_i <= ec_seq_pkg::MBOX_LAST) ? mem[addr_a_i]
                                                         : 8'h00;
        rdata_b_o <= (addr_b_i <= ec_seq_pkg::MBOX_LAST) ? mem[addr_b_i]
                                                         : 8'h00;
    end
endmodule
`default_nettype wire

// [test/ec_mailbox_power_sequencer_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
`define WT(s, v, n) for (w = 0; w < n && s !== v; w++) step(1);
module ec_mailbox_power_sequencer_tb_top;
    logic       clock_i = 0, rst_i = 1, host_wr_i = 0, host_rd_i = 0;
    logic       host_port_i = 0, ec_wr_i = 0, smi_enable_i = 0;
    logic       power_switch_i = 0, parallel_host_i = 0;
    logic       clock_restart_i = 0, bad_sum = 0, fv, pg;
    logic [7:0] host_wdata_i = 0, ec_wdata_i = 0, host_rdata_o, ec_rdata_o;
    logic [7:0] fb, d, v;
    logic [5:0] ec_addr_i = 0;
    logic [2:0] planes;
    logic       ec_irq_o, smi_o, flash_req_o, resume_n, sys_n;
    logic       rom_o, run_o, rec_o, led_o, prog_o, sb_ready;
    localparam int FLASH_SIM = 256;
    int         failures = 0, n_checks = 0, seed = 9, cyc = 0;
    int         irqs = 0, smis = 0, k, j, w, idx;
    ec_mailbox_power_sequencer #(.BLINK_CYCLES(4), .HOLD_CYCLES(8),
        .FLASH_BYTES(FLASH_SIM)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .host_wr_i(host_wr_i),
        .host_rd_i(host_rd_i), .host_port_i(host_port_i),
        .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
        .ec_wr_i(ec_wr_i), .ec_addr_i(ec_addr_i), .ec_wdata_i(ec_wdata_i),
        .ec_rdata_o(ec_rdata_o), .smi_enable_i(smi_enable_i),
        .ec_irq_o(ec_irq_o), .system_management_interrupt_o(smi_o),
        .flash_valid_i(fv), .flash_byte_i(fb), .flash_req_o(flash_req_o),
        .power_switch_pin_i_unused_o(), .power_switch_i(power_switch_i),
        .power_good_in_i(pg), .parallel_host_i(parallel_host_i),
        .clock_restart_i(clock_restart_i), .resume_reset_out_n_o(resume_n),
        .system_reset_out_n_o(sys_n), .rom_to_host_o(rom_o),
        .ec_clock_run_o(run_o), .recovery_o(rec_o), .led_blink_o(led_o),
        .program_port_ready_o(prog_o));
    power_partner #(.FLASH_BYTES(FLASH_SIM)) pp (
        .clock_i(clock_i), .rst_i(rst_i), .bad_sum_i(bad_sum),
        .flash_req_i(flash_req_o), .resume_n_i(resume_n),
        .sys_reset_n_i(sys_n), .ready_o(sb_ready),
        .flash_valid_o(fv), .flash_byte_o(fb), .power_good_o(pg),
        .planes_o(planes));
    initial forever #5 clock_i = ~clock_i;
    task test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        irqs += ec_irq_o;
        smis += smi_o;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    task step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task hw(input logic p, input logic [7:0] val);
        host_port_i = p;
        host_wdata_i = val;
        host_wr_i = 1;
        step(1);
        host_wr_i = 0;
        step(1);
    endtask
    task hr(input logic p, output logic [7:0] val);
        host_port_i = p;
        host_rd_i = 1;
        step(1);
        host_rd_i = 0;
        step(1);
        val = host_rdata_o;
    endtask
    task ew(input logic [5:0] a, input logic [7:0] val);
        ec_addr_i = a;
        ec_wdata_i = val;
        ec_wr_i = 1;
        step(1);
        ec_wr_i = 0;
        step(1);
    endtask
    task er(input logic [5:0] a, output logic [7:0] val);
        ec_addr_i = a;
        step(3);
        val = ec_rdata_o;
    endtask
    // refused indices read as zero
    function automatic logic [7:0] mexp(int i, logic [7:0] val);
        return (i >= ec_seq_pkg::MBOX_COUNT) ? 8'h00 : val;
    endfunction
    initial begin
        step(10);
        rst_i = 0;
        step(2);
        `CHK(flash_req_o, 1'b1)
        `CHK(sys_n, 1'b0)
        for (k = 0; k < 12; k++) begin
            idx = (k == 0) ? 43 : (k == 1) ? 44 : (k == 2) ? 63 :
                  2 + ($unsigned($random(seed)) % 42);
            d = $random(seed);
            hw(ec_seq_pkg::PORT_INDEX, 8'(idx));
            hr(ec_seq_pkg::PORT_INDEX, v);
            `CHK(v[5:0], 6'(idx))
            hw(ec_seq_pkg::PORT_DATA, d);
            hr(ec_seq_pkg::PORT_DATA, v);
            `CHK(v, mexp(idx, d))
            er(6'(idx), v);
            `CHK(v, mexp(idx, d))
            d = ~d;
            ew(6'(idx), d);
            hr(ec_seq_pkg::PORT_DATA, v);
            `CHK(v, mexp(idx, d))
        end
        `CHK(irqs + smis, 0)
        hw(ec_seq_pkg::PORT_INDEX, 8'(ec_seq_pkg::MBOX_HOST_MSG));
        hw(ec_seq_pkg::PORT_DATA, d);
        step(4);
        `CHK(irqs, 1)
        for (k = 0; k < 2; k++) begin
            smi_enable_i = k[0];
            j = smis;
            ew(ec_seq_pkg::MBOX_EC_MSG, d);
            step(4);
            `CHK(smis, j + k)
        end
        `WT(flash_req_o, 1'b0, 2000)
        `CHK(flash_req_o, 1'b0)
        step(20);
        `CHK(rec_o, 1'b0)
        `CHK(resume_n, 1'b1)
        power_switch_i = 1;
        step(5);
        power_switch_i = 0;
        `WT(resume_n, 1'b0, 20)
        `CHK(resume_n, 1'b0)
        step(1);
        `CHK(planes, 3'h7)
        `WT(pg, 1'b1, 100)
        j = cyc;
        `CHK(sys_n, 1'b0)
        `WT(sys_n, 1'b1, 40)
        `CHK(sys_n, 1'b1)
        `CHK(cyc - j >= 8, 1'b1)
        `CHK(rom_o, 1'b1)
        `CHK(run_o, 1'b0)
        step(1);
        `CHK(sb_ready, 1'b1)
        clock_restart_i = 1;
        step(5);
        clock_restart_i = 0;
        `WT(rom_o, 1'b0, 20)
        `CHK(rom_o, 1'b0)
        `CHK(run_o, 1'b1)
        rst_i = 1;
        bad_sum = 1;
        step(10);
        rst_i = 0;
        `WT(rec_o, 1'b1, 2000)
        `CHK(rec_o, 1'b1)
        j = 0;
        d[0] = led_o;
        repeat (20) begin
            step(1);
            j += (led_o !== d[0]);
            d[0] = led_o;
        end
        `CHK(j > 0, 1'b1)
        power_switch_i = 1;
        step(10);
        `CHK(resume_n, 1'b1)
        parallel_host_i = 1;
        `WT(prog_o, 1'b1, 20)
        `CHK(prog_o, 1'b1)
        test_done();
    end
endmodule
`default_nettype wire

// [test/power_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module power_partner #(
    parameter int PG_DELAY    = 20,
    parameter int FLASH_BYTES = ec_seq_pkg::FLASH_BYTES
) (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       bad_sum_i,
    input  wire logic       flash_req_i,
    input  wire logic       resume_n_i,
    input  wire logic       sys_reset_n_i,
    output logic            ready_o,
    output logic            flash_valid_o,
    output logic      [7:0] flash_byte_o,
    output logic            power_good_o,
    output logic      [2:0] planes_o
);
    logic [19:0] cnt;
    int          pg;
    // flash image, idle data lines toggle
    always_ff @(posedge clock_i) begin
        flash_valid_o <= 1'b0;
        flash_byte_o  <= ~flash_byte_o;
        if (rst_i) begin
            cnt          <= 20'h00000;
            flash_byte_o <= 8'h5A;
        end else if (flash_req_i && 32'(cnt) < FLASH_BYTES) begin
            flash_valid_o <= 1'b1;
            flash_byte_o  <= (cnt == 0 && bad_sum_i) ? 8'h02 : 8'h01;
            cnt           <= cnt + 20'h00001;
        end
    end
    // suspend planes and power good
    always_ff @(posedge clock_i) begin
        planes_o <= resume_n_i ? 3'h0 : 3'h7;
        ready_o  <= !rst_i && sys_reset_n_i && planes_o == 3'h7;
        if (rst_i || planes_o !== 3'h7) begin
            pg           <= 0;
            power_good_o <= 1'b0;
        end else if (pg < PG_DELAY) begin
            pg <= pg + 1;
        end else begin
            power_good_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire
